/* hw/amem_top.sv */
// top: APB registers, motion error capture, servo enable and driver alarm handling
//
// Chosen here: the placing of the registers and the APB slave port.
module amem_top
	import amem_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AMEM_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire amem_drv_s drv_pins,
	input wire amem_axis_s [AMEM_AXES-1:0] axis_in,
	output logic servo_on,
	output logic driver_reset_command_out,
	output logic driver_alarm_clear_command_out,
	output logic motion_error,
	output logic irq
);
	logic rst_m_q;
	logic rst_n_s;
	amem_drv_s drv_m_q;
	amem_drv_s drv_s_q;
	logic [AMEM_SW-1:0] live [AMEM_AXES];
	logic [AMEM_SW-1:0] flags [AMEM_AXES];
	logic [AMEM_SW-1:0] mask_q [AMEM_AXES];
	logic [AMEM_AXES-1:0] match;
	logic match_any;
	logic [1:0] first_idx;
	logic err_q;
	logic [1:0] err_axis_q;
	logic servo_q;
	logic [7:0] code_q;
	logic alarm_p_q;
	logic warn_p_q;
	logic [AMEM_IRQ_W-1:0] ist_q;
	logic [AMEM_IRQ_W-1:0] imask_q;
	logic [AMEM_IRQ_W-1:0] evt;
	logic [AMEM_DRST_CW-1:0] drst_cnt_q;
	logic dclr_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic [31:0] rd_val;
	logic rd_hit;
	logic setup;
	logic wr_en;
	logic wr_ctrl;
	logic home_pulse;
	logic drst_pulse;
	logic dclr_pulse;
	logic clr_err;
	logic [1:0] wr_mslot;
	logic [1:0] rd_mslot;
	logic [1:0] rd_fslot;

	// reset release through two flops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_m_q <= 1'b0;
			rst_n_s <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_n_s <= rst_m_q;
		end
	end

	// driver pins come from another unit
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			drv_m_q <= '0;
			drv_s_q <= '0;
		end else begin
			drv_m_q <= drv_pins;
			drv_s_q <= drv_m_q;
		end
	end

	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite;
	assign wr_ctrl = wr_en && paddr == OFS_CTRL;
	assign home_pulse = wr_ctrl && pwdata[CTRL_HOME];
	assign drst_pulse = wr_ctrl && pwdata[CTRL_DRST];
	assign dclr_pulse = wr_ctrl && pwdata[CTRL_DCLR];
	assign clr_err = home_pulse || drst_pulse;
	assign wr_mslot = amem_slot(paddr, OFS_MASK);
	assign rd_mslot = amem_slot(paddr, OFS_MASK);
	assign rd_fslot = amem_slot(paddr, OFS_FLAGS);

	// live status words, driver conditions on axis 0
	always_comb begin
		for (int i = 0; i < AMEM_AXES; i++) begin
			live[i] = amem_axis_word(axis_in[i]);
		end
		live[0][ST_COMM] = drv_s_q.comm_fault;
		live[0][ST_ALARM] = drv_s_q.alarm;
	end

	amem_axis_eval #(.USE(AMEM_USE_AX0)) u_ax0 (
		.clk(clk),
		.rst_n(rst_n_s),
		.live(live[0]),
		.mask(mask_q[0]),
		.clear(clr_err),
		.flags(flags[0]),
		.match(match[0])
	);

	amem_axis_eval #(.USE(AMEM_USE_AX1)) u_ax1 (
		.clk(clk),
		.rst_n(rst_n_s),
		.live(live[1]),
		.mask(mask_q[1]),
		.clear(clr_err),
		.flags(flags[1]),
		.match(match[1])
	);

	amem_axis_eval #(.USE(AMEM_USE_AX2)) u_ax2 (
		.clk(clk),
		.rst_n(rst_n_s),
		.live(live[2]),
		.mask(mask_q[2]),
		.clear(clr_err),
		.flags(flags[2]),
		.match(match[2])
	);

	assign match_any = |match;

	// lowest axis wins a tie
	always_comb begin
		first_idx = 2'h0;
		for (int i = AMEM_AXES - 1; i >= 0; i--) begin
			if (match[i]) begin
				first_idx = 2'(i);
			end
		end
	end

	// error wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			err_q <= 1'b0;
		end else if (match_any) begin
			err_q <= 1'b1;
		end else if (clr_err) begin
			err_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			err_axis_q <= 2'h0;
		end else if (match_any && !err_q) begin
			err_axis_q <= first_idx;
		end
	end

	// servo switch: error forces off
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			servo_q <= 1'b0;
		end else if (match_any) begin
			servo_q <= 1'b0;
		end else if (drst_pulse) begin
			servo_q <= 1'b0;
		end else if (wr_ctrl) begin
			servo_q <= pwdata[CTRL_SERVO];
		end
	end

	// driver code: idle value unless alarm or warning
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			code_q <= AMEM_CODE_IDLE;
		end else if (drv_s_q.alarm || drv_s_q.warning) begin
			code_q <= drv_s_q.code;
		end else begin
			code_q <= AMEM_CODE_IDLE;
		end
	end

	// driver reset pin held for a fixed time
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			drst_cnt_q <= '0;
		end else if (drst_pulse) begin
			drst_cnt_q <= AMEM_DRST_CW'(AMEM_DRV_RST_CYC);
		end else if (drst_cnt_q != '0) begin
			drst_cnt_q <= drst_cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			dclr_q <= 1'b0;
		end else begin
			dclr_q <= dclr_pulse;
		end
	end

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			for (int i = 0; i < AMEM_AXES; i++) begin
				mask_q[i] <= AMEM_MASK_RST;
			end
		end else if (wr_en && wr_mslot != AMEM_NO_SLOT) begin
			mask_q[wr_mslot] <= pwdata[AMEM_SW-1:0];
		end
	end

	assign evt[IRQ_ERR] = match_any && !err_q;
	assign evt[IRQ_ALARM] = drv_s_q.alarm && !alarm_p_q;
	assign evt[IRQ_WARN] = drv_s_q.warning && !warn_p_q;

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			alarm_p_q <= 1'b0;
			warn_p_q <= 1'b0;
		end else begin
			alarm_p_q <= drv_s_q.alarm;
			warn_p_q <= drv_s_q.warning;
		end
	end

	// sticky events, write one clears, new event wins
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			ist_q <= '0;
		end else if (wr_en && paddr == OFS_ISTAT) begin
			ist_q <= (ist_q & ~pwdata[AMEM_IRQ_W-1:0]) | evt;
		end else begin
			ist_q <= ist_q | evt;
		end
	end

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			imask_q <= '0;
		end else if (wr_en && paddr == OFS_IMASK) begin
			imask_q <= pwdata[AMEM_IRQ_W-1:0];
		end
	end

	always_comb begin
		rd_val = '0;
		rd_hit = 1'b1;
		if (rd_mslot != AMEM_NO_SLOT) begin
			rd_val[AMEM_SW-1:0] = mask_q[rd_mslot];
		end else if (rd_fslot != AMEM_NO_SLOT) begin
			rd_val[AMEM_SW-1:0] = flags[rd_fslot];
		end else begin
			case (paddr)
				OFS_CTRL: rd_val[CTRL_SERVO] = servo_q;
				OFS_STAT: begin
					rd_val[STAT_ERR] = err_q;
					rd_val[STAT_AXIS +: 2] = err_axis_q;
					rd_val[STAT_ALARM] = drv_s_q.alarm;
					rd_val[STAT_WARN] = drv_s_q.warning;
				end
				OFS_CODE: rd_val[7:0] = code_q;
				OFS_DIN: begin
					rd_val[DIN_ALARM] = drv_s_q.alarm;
					rd_val[DIN_WARN] = drv_s_q.warning;
				end
				OFS_ISTAT: rd_val[AMEM_IRQ_W-1:0] = ist_q;
				OFS_IMASK: rd_val[AMEM_IRQ_W-1:0] = imask_q;
				default: rd_hit = 1'b0;
			endcase
		end
	end

	// answer prepared in setup, zero wait access
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			prdata_q <= '0;
			pslverr_q <= 1'b0;
		end else if (setup) begin
			prdata_q <= pwrite ? '0 : rd_val;
			pslverr_q <= !rd_hit;
		end
	end

	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign pready = 1'b1;
	assign servo_on = servo_q;
	assign motion_error = err_q;
	assign driver_reset_command_out = drst_cnt_q != '0;
	assign driver_alarm_clear_command_out = dclr_q;
	assign irq = |(ist_q & imask_q);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n_s);

	property p_err_from_match;
		$rose(err_q) |-> $past(match_any);
	endproperty
	a_err_from_match: assert property (p_err_from_match) else $error("error without match");

	property p_servo_drop;
		match_any |=> !servo_on ##1 (!servo_on || $past(wr_ctrl));
	endproperty
	a_servo_drop: assert property (p_servo_drop) else $error("servo stayed on");

	property p_servo_follow;
		wr_ctrl && !match_any && !drst_pulse |=> servo_on == $past(pwdata[CTRL_SERVO]);
	endproperty
	a_servo_follow: assert property (p_servo_follow) else $error("servo not following");

	property p_err_hold;
		err_q && !clr_err |=> err_q;
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error flag dropped");

	property p_err_set;
		match_any |=> err_q && motion_error;
	endproperty
	a_err_set: assert property (p_err_set) else $error("error flag not set");

	property p_first_axis;
		match_any && !err_q |=> err_axis_q == $past(first_idx) ##1 $stable(err_axis_q);
	endproperty
	a_first_axis: assert property (p_first_axis) else $error("wrong error axis");

	property p_home_clear;
		home_pulse && !match_any |=> !err_q;
	endproperty
	a_home_clear: assert property (p_home_clear) else $error("homing did not clear");

	property p_drst;
		drst_pulse |=> driver_reset_command_out && !servo_on;
	endproperty
	a_drst: assert property (p_drst) else $error("driver reset missing");

	property p_alarm_bit;
		drv_s_q.alarm |=> flags[0][ST_ALARM];
	endproperty
	a_alarm_bit: assert property (p_alarm_bit) else $error("alarm bit not set");

	property p_code_idle;
		!drv_s_q.alarm && !drv_s_q.warning |=> code_q == AMEM_CODE_IDLE;
	endproperty
	a_code_idle: assert property (p_code_idle) else $error("code not idle");

	property p_warn_keeps;
		drv_s_q.warning && servo_on && !match_any && !wr_ctrl |=> servo_on;
	endproperty
	a_warn_keeps: assert property (p_warn_keeps) else $error("warning disabled driver");

	property p_dclr;
		dclr_pulse |=> driver_alarm_clear_command_out ##1 !driver_alarm_clear_command_out || $past(dclr_pulse);
	endproperty
	a_dclr: assert property (p_dclr) else $error("clear pulse wrong");

	property p_unused_bit;
		flags[0][0] == 1'b0 && flags[2][ST_OVERSPEED] == 1'b0 && flags[1][ST_FE_LIM] == 1'b0;
	endproperty
	a_unused_bit: assert property (p_unused_bit) else $error("absent bit set");

	c_error: cover property (match_any && !err_q ##1 err_q);
	c_home: cover property (err_q ##1 home_pulse ##1 !err_q);
	c_warn: cover property ($rose(drv_s_q.warning) ##2 code_q != AMEM_CODE_IDLE);
	c_irq: cover property ($rose(irq));
endmodule

/* hw/amem_pkg.sv */
// package: register map, field layout, carriers and helpers of the axis motion error monitor
// Functional notes
// - all axes checked every cycle, always running
// - status AND mask non-zero raises error
// - servo enable output follows software switch
// - motion error turns servo enable off
// - error flag set, held until cleared
// - first faulting axis index captured, held
// - homing command clears error and status
// - driver reset resets driver and controller
// - axis0 bits 1,2,3 warn, comm, alarm
// - bits 4-7, 9-11 all axes; bit0 unused
// - bit8 axis0 only, bit12 axis1 only
// - per-axis mask, resets to 268
// - driver alarm sets axis0 bit3, input 24
// - driver code register, 99 hex when idle
// - warning sets input 25, loads code only
// - alarm clear command pulses driver clear
// - driver link fault sets status bit 2
package amem_pkg;
	localparam int AMEM_AXES = 3;
	localparam int AMEM_SW = 13;
	localparam int AMEM_AW = 8;
	localparam int AMEM_IRQ_W = 3;
	localparam int AMEM_CLK_NS = 8;
	localparam int AMEM_DRV_RST_NS = 1000;
	localparam int AMEM_DRV_RST_CYC = (AMEM_DRV_RST_NS + AMEM_CLK_NS - 1) / AMEM_CLK_NS;
	localparam int AMEM_DRST_CW = $clog2(AMEM_DRV_RST_CYC + 1);
	localparam int ST_FE_WARN = 1;
	localparam int ST_COMM = 2;
	localparam int ST_ALARM = 3;
	localparam int ST_FWD_LIM = 4;
	localparam int ST_REV_LIM = 5;
	localparam int ST_HOMING = 6;
	localparam int ST_HOLD = 7;
	localparam int ST_FE_LIM = 8;
	localparam int ST_FWD_SOFT = 9;
	localparam int ST_REV_SOFT = 10;
	localparam int ST_CANCEL = 11;
	localparam int ST_OVERSPEED = 12;
	localparam logic [AMEM_SW-1:0] AMEM_USE_AX0 = 13'h0ffe;
	localparam logic [AMEM_SW-1:0] AMEM_USE_AX1 = 13'h1ef0;
	localparam logic [AMEM_SW-1:0] AMEM_USE_AX2 = 13'h0ef0;
	localparam logic [AMEM_SW-1:0] AMEM_MASK_RST = 13'h010c;
	localparam logic [7:0] AMEM_CODE_IDLE = 8'h99;
	localparam logic [AMEM_AW-1:0] OFS_CTRL = 8'h00;
	localparam logic [AMEM_AW-1:0] OFS_STAT = 8'h04;
	localparam logic [AMEM_AW-1:0] OFS_MASK = 8'h08;
	localparam logic [AMEM_AW-1:0] OFS_FLAGS = 8'h14;
	localparam logic [AMEM_AW-1:0] OFS_CODE = 8'h20;
	localparam logic [AMEM_AW-1:0] OFS_DIN = 8'h24;
	localparam logic [AMEM_AW-1:0] OFS_ISTAT = 8'h28;
	localparam logic [AMEM_AW-1:0] OFS_IMASK = 8'h2c;
	localparam int CTRL_SERVO = 0;
	localparam int CTRL_HOME = 1;
	localparam int CTRL_DRST = 2;
	localparam int CTRL_DCLR = 3;
	localparam int STAT_ERR = 0;
	localparam int STAT_AXIS = 4;
	localparam int STAT_ALARM = 8;
	localparam int STAT_WARN = 9;
	localparam int IRQ_ERR = 0;
	localparam int IRQ_ALARM = 1;
	localparam int IRQ_WARN = 2;
	localparam int DIN_ALARM = 24;
	localparam int DIN_WARN = 25;
	localparam logic [1:0] AMEM_NO_SLOT = 2'h3;

	typedef struct packed {
		logic alarm;
		logic warning;
		logic comm_fault;
		logic [7:0] code;
	} amem_drv_s;

	typedef struct packed {
		logic fe_warn;
		logic fe_limit;
		logic fwd_limit;
		logic rev_limit;
		logic homing;
		logic feed_hold;
		logic fwd_soft;
		logic rev_soft;
		logic cancelling;
		logic overspeed;
	} amem_axis_s;

	function automatic logic [AMEM_SW-1:0] amem_axis_word(input amem_axis_s a);
		logic [AMEM_SW-1:0] w;
		w = '0;
		w[ST_FE_WARN] = a.fe_warn;
		w[ST_FWD_LIM] = a.fwd_limit;
		w[ST_REV_LIM] = a.rev_limit;
		w[ST_HOMING] = a.homing;
		w[ST_HOLD] = a.feed_hold;
		w[ST_FE_LIM] = a.fe_limit;
		w[ST_FWD_SOFT] = a.fwd_soft;
		w[ST_REV_SOFT] = a.rev_soft;
		w[ST_CANCEL] = a.cancelling;
		w[ST_OVERSPEED] = a.overspeed;
		return w;
	endfunction

	// word slot of a per-axis register block, or no slot
	function automatic logic [1:0] amem_slot(input logic [AMEM_AW-1:0] a,
		input logic [AMEM_AW-1:0] base);
		logic [AMEM_AW-1:0] d;
		d = a - base;
		if (a >= base && d < AMEM_AW'(4 * AMEM_AXES) && d[1:0] == 2'h0) begin
			return d[3:2];
		end
		return AMEM_NO_SLOT;
	endfunction
endpackage

/* hw/amem_axis_eval.sv */
// one axis: condition flag word, mask compare
module amem_axis_eval
	import amem_pkg::*;
#(
	parameter logic [AMEM_SW-1:0] USE = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [AMEM_SW-1:0] live,
	input wire logic [AMEM_SW-1:0] mask,
	input wire logic clear,
	output logic [AMEM_SW-1:0] flags,
	output logic match
);
	logic [AMEM_SW-1:0] flags_q;
	logic [AMEM_SW-1:0] flags_d;
	logic [AMEM_SW-1:0] now;

	// bits not present on this axis never set
	// a clear drops held bits before the compare, live bits still count
	assign now = (live | (clear ? '0 : flags_q)) & USE;
	assign match = |(now & mask);
	// live conditions win over a clear
	assign flags_d = (live & USE) | (clear ? '0 : flags_q);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= '0;
		end else begin
			flags_q <= flags_d;
		end
	end

	assign flags = flags_q;
endmodule

/* verif/amem_drv_model.sv */
// servo driver model: alarm, warning and link fault reporting
module amem_drv_model
	import amem_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic servo_on,
	input wire logic driver_reset_command_out,
	input wire logic driver_alarm_clear_command_out,
	input wire logic [1:0] kind,
	input wire logic go,
	input wire logic [7:0] code,
	input wire logic clearable,
	output amem_drv_s drv,
	output logic unsafe_q
);
	logic al_q;
	logic wn_q;
	logic cf_q;
	logic [7:0] code_q;
	logic [7:0] idle_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			al_q <= 1'b0;
			wn_q <= 1'b0;
			cf_q <= 1'b0;
			code_q <= 8'h00;
		end else if (driver_reset_command_out) begin
			al_q <= 1'b0;
			wn_q <= 1'b0;
			cf_q <= 1'b0;
		end else if (driver_alarm_clear_command_out && clearable) begin
			al_q <= 1'b0;
		end else if (go) begin
			al_q <= al_q | (kind == 2'h1);
			wn_q <= wn_q | (kind == 2'h2);
			cf_q <= cf_q | (kind == 2'h3);
			code_q <= code;
		end
	end

	// alarm dropped while still enabled means an unsafe restart
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			unsafe_q <= 1'b0;
			idle_q <= 8'h00;
		end else begin
			idle_q <= idle_q + 8'h5b;
			if (al_q && driver_alarm_clear_command_out && clearable && servo_on) begin
				unsafe_q <= 1'b1;
			end
		end
	end

	// code lines carry junk when nothing is reported
	assign drv = '{alarm: al_q, warning: wn_q, comm_fault: cf_q,
		code: (al_q | wn_q) ? code_q : idle_q};
endmodule

/* verif/tb_amem_top.sv */
// self-checking bench of the axis motion error monitor
module tb_amem_top
	import amem_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] EXP [3] = '{32'h0ff2, 32'h1ef0, 32'h0ef0};
	localparam amem_axis_s AX_FWD = '{fwd_limit: 1'b1, default: 1'b0};
	localparam amem_axis_s AX_REV = '{rev_limit: 1'b1, default: 1'b0};
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready;
	logic pslverr;
	logic servo_on;
	logic driver_reset_command_out;
	logic driver_alarm_clear_command_out;
	logic motion_error;
	logic irq;
	logic unsafe;
	logic go = 1'b0;
	logic [1:0] kind = 2'h0;
	logic [7:0] code = 8'h00;
	amem_drv_s drv;
	amem_axis_s [2:0] axis_in = '0;
	int bad_count = 0;
	int n_checks = 0;
	int n;

	always #4 clk = ~clk;

	amem_top amem_top_i (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .drv_pins(drv), .axis_in(axis_in),
		.servo_on(servo_on), .driver_reset_command_out(driver_reset_command_out),
		.driver_alarm_clear_command_out(driver_alarm_clear_command_out), .motion_error(motion_error), .irq(irq));

	amem_drv_model amem_drv_model_i (.clk(clk), .rstn(rstn), .servo_on(servo_on),
		.driver_reset_command_out(driver_reset_command_out), .driver_alarm_clear_command_out(driver_alarm_clear_command_out), .kind(kind),
		.go(go), .code(code), .clearable(1'b1), .drv(drv), .unsafe_q(unsafe));

	task automatic stop_test();
		if (bad_count == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] e, input string s);
		n_checks++;
		if (got !== e) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, s, got, e);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic e);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			bad_count++;
			stop_test();
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(32'(pslverr), 32'(e), "slverr");
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 1'b0);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string s);
		apb(1'b0, a, 32'h0, 1'b0);
		chk(rd, e, s);
	endtask

	task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input string s);
		int k;
		k = 0;
		do begin
			apb(1'b0, a, 32'h0, 1'b0);
			k++;
		end while ((rd & m) !== e && k < 20);
		chk(rd & m, e, s);
	endtask

	task automatic fault(input logic [1:0] kd, input logic [7:0] c);
		@(posedge clk);
		kind <= kd;
		code <= c;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
	endtask

	initial begin
		#200us;
		bad_count++;
		stop_test();
	end

	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 3; i++) begin
			rdchk(OFS_MASK + 8'(4 * i), 32'h10c, "mask rst");
			rdchk(OFS_FLAGS + 8'(4 * i), 32'h0, "flags rst");
		end
		rdchk(OFS_CODE, 32'h99, "idle code");
		apb(1'b0, 8'hfc, 32'h0, 1'b1);
		chk(rd, 32'h0, "unmapped");
		apb(1'b1, 8'hfc, 32'h1, 1'b1);
		wr(OFS_CTRL, 32'h1);
		@(negedge clk);
		chk(32'(servo_on), 32'h1, "servo on");
		rdchk(OFS_CTRL, 32'h1, "switch");
		wr(OFS_MASK, 32'h0);
		wr(OFS_MASK + 8'h4, 32'h10);
		wr(OFS_MASK + 8'h8, 32'h20);
		rdchk(OFS_MASK + 8'h8, 32'h20, "own mask");
		@(posedge clk);
		axis_in <= {AX_REV, AX_FWD, 10'h0};
		@(posedge clk);
		@(negedge clk);
		chk(32'(motion_error), 32'h1, "error");
		chk(32'(servo_on), 32'h0, "servo off");
		wr(OFS_MASK, 32'h10);
		@(posedge clk);
		axis_in <= {20'h0, AX_FWD};
		@(posedge clk);
		axis_in <= '0;
		rdchk(OFS_STAT, 32'h11, "first axis");
		rdchk(OFS_FLAGS + 8'h4, 32'h10, "flags ax1");
		chk(32'(motion_error), 32'h1, "held");
		wr(OFS_CTRL, 32'h2);
		@(negedge clk);
		chk(32'(motion_error), 32'h0, "homing");
		rdchk(OFS_FLAGS + 8'h4, 32'h0, "flags clr");
		for (int i = 0; i < 3; i++) wr(OFS_MASK + 8'(4 * i), 32'h0);
		@(posedge clk);
		axis_in <= '1;
		for (int i = 0; i < 3; i++) begin
			rdchk(OFS_FLAGS + 8'(4 * i), EXP[i], "use bits");
		end
		wr(OFS_MASK + 8'h8, 32'h1001);
		@(negedge clk);
		chk(32'(motion_error), 32'h0, "absent bits");
		@(posedge clk);
		axis_in <= '0;
		wr(OFS_CTRL, 32'h2);
		wr(OFS_MASK, 32'h10c);
		wr(OFS_ISTAT, 32'h7);
		fault(2'h1, 8'h3a);
		poll(OFS_DIN, 32'h1 << DIN_ALARM, 32'h1 << DIN_ALARM, "din24");
		poll(OFS_CODE, 32'hff, 32'h3a, "alarm code");
		rdchk(OFS_FLAGS, 32'h8, "alarm bit");
		chk(32'(motion_error), 32'h1, "alarm err");
		chk(32'(irq), 32'h0, "irq masked");
		rdchk(OFS_ISTAT, 32'h3, "istat");
		wr(OFS_IMASK, 32'h3);
		@(negedge clk);
		chk(32'(irq), 32'h1, "irq");
		wr(OFS_ISTAT, 32'h3);
		@(negedge clk);
		chk(32'(irq), 32'h0, "irq w1c");
		wr(OFS_CTRL, 32'h0);
		wr(OFS_CTRL, 32'h8);
		@(negedge clk);
		chk(32'(driver_alarm_clear_command_out), 32'h1, "clear pulse");
		@(negedge clk);
		chk(32'(driver_alarm_clear_command_out), 32'h0, "clear pulse end");
		poll(OFS_DIN, 32'h1 << DIN_ALARM, 32'h0, "alarm clr");
		chk(32'(unsafe), 32'h0, "unsafe");
		wr(OFS_CTRL, 32'h2);
		poll(OFS_CODE, 32'hff, 32'h99, "code idle");
		wr(OFS_CTRL, 32'h1);
		fault(2'h2, 8'h91);
		poll(OFS_DIN, 32'h1 << DIN_WARN, 32'h1 << DIN_WARN, "din25");
		poll(OFS_CODE, 32'hff, 32'h91, "warn code");
		chk(32'(servo_on), 32'h1, "warn servo");
		chk(32'(motion_error), 32'h0, "warn err");
		fault(2'h3, 8'h91);
		poll(OFS_FLAGS, 32'h4, 32'h4, "comm bit");
		chk(32'(motion_error), 32'h1, "comm err");
		wr(OFS_CTRL, 32'h4);
		n = 0;
		for (int k = 0; k < 300; k++) begin
			@(negedge clk);
			if (driver_reset_command_out === 1'b1) n++;
			else if (n > 0) break;
		end
		chk(32'(n), 32'(AMEM_DRV_RST_CYC), "rst len");
		poll(OFS_CODE, 32'hff, 32'h99, "rst code");
		wr(OFS_CTRL, 32'h2);
		wr(OFS_MASK + 8'h8, 32'h20);
		@(posedge clk);
		axis_in[2].rev_limit <= 1'b1;
		@(posedge clk);
		axis_in <= '0;
		@(negedge clk);
		chk(32'(motion_error), 32'h1, "err ax2");
		wr(OFS_CTRL, 32'h4);
		@(negedge clk);
		chk(32'(motion_error), 32'h0, "driver_reset_command");
		stop_test();
	end
endmodule
